// >>> src/qcd_top.sv
// Purpose: admission / tail-drop / early random discard for one port queue
// Assumes: frames arrive as one-beat descriptors (length in bytes)
// Notes: admitted descriptors sit in a small FIFO toward the egress scheduler
`timescale 1ns/1ps
`default_nettype none

module qcd_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wp, rp, next_wp, next_rp;
  logic [AW:0]      cnt, next_cnt;
  logic             push, pop;
  always_comb begin
    push     = in_valid && in_ready;
    pop      = out_valid && out_ready;
    next_wp  = push ? AW'(wp + 1'b1) : wp;
    next_rp  = pop ? AW'(rp + 1'b1) : rp;
    next_cnt = (AW+1)'(cnt + push - pop);
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      wp  <= '0;
      rp  <= '0;
      cnt <= '0;
    end else begin
      wp  <= next_wp;
      rp  <= next_rp;
      cnt <= next_cnt;
    end
    if (push) mem[wp] <= in_data;
  end
  assign in_ready  = (cnt != (AW+1)'(DEPTH));
  assign out_valid = (cnt != '0);
  assign out_data  = mem[rp];
endmodule // qcd_fifo

////////////////////////////////////////////////////////////////////////////////

// How it works
// - with nothing configured, frames queue in order until the buffer is full.
// - queue past a priority threshold drops new frames of that priority.
// - each port holds one port threshold and eight priority thresholds.
// - port threshold bounds the port; priority share bounds each priority.
// - sums below 100 are used as set, never scaled up.
// - each multicast class has its own packet-count tail-drop threshold.
// - profile identifiers run from 0 to 384.
// - profile holds min fill, max fill and drop probability percentages.
// - min and max percentages become bytes of the port buffer size.
// - at or above min fill, frames drop randomly per drop probability.
// - above max fill every enqueued frame drops.
// - each priority maps to a profile, and the map can be removed.
// - at most four distinct profiles per port group.
// - a trunk port shares no profile with other ports.
// - no more than 384 profiles in the device.
// - aggregated_link members apply per port; failure names the member. The code records the rejected priority index instead.
module qcd_top import qcd_pkg::*; #(
  parameter int unsigned BUF_BYTES = 32'd65536,
  parameter int unsigned LEN_W     = 14
) (
  input  wire logic             CLOCK,
  input  wire logic             SYS_RST,
  input  wire logic [11:0]      AVS_ADDRESS,
  input  wire logic             AVS_READ,
  input  wire logic             AVS_WRITE,
  input  wire logic [31:0]      AVS_WRITEDATA,
  input  wire logic [3:0]       AVS_BYTEENABLE,
  output logic [31:0]           AVS_READDATA,
  output logic                  AVS_WAITREQUEST,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  input  wire logic [LEN_W-1:0] IN_LEN,
  input  wire logic [2:0]       IN_PRIO,
  input  wire logic             IN_MCAST,
  output logic                  DROP_PULSE,
  output logic [2:0]            DROP_REASON,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY,
  output logic [LEN_W+3:0]      OUT_DESC,
  input  wire logic             OUT_FREE,
  input  wire logic [LEN_W-1:0] OUT_FREE_LEN
);
  localparam int unsigned FW = 32;

  // configuration
  logic [31:0] ctrl, port_thr, next_ctrl, next_port_thr;
  logic [6:0]  prio_pct [NUM_PRIO];
  logic [15:0] mc_thr   [NUM_TC];
  logic [9:0]  prof_map [NUM_PRIO];   // bit9 = mapped, [8:0] = id
  logic [30:0] slot     [NUM_SLOT];   // [30:24] min, [23:17] max, [16:10] prob, [9:0] id+valid
  logic [7:0]  status, next_status;
  // queue state
  logic [FW-1:0] fill, next_fill;
  logic [FW-1:0] prio_fill [NUM_PRIO];
  logic [15:0]   mc_cnt    [NUM_TC];
  logic [15:0]   lfsr, next_lfsr;
  logic [31:0]   drops, accepts, next_drops, next_accepts;

  ////////////////////////////////////////////////////////////////////////////
  // bus: answers in one wait cycle, so waitrequest is a registered handshake
  logic        acc_done, next_acc_done;
  logic        waitreq;
  logic [31:0] rdata, next_rdata;
  logic        wr_go, rd_go;
  logic [2:0]  idx;
  always_comb begin
    wr_go = AVS_WRITE && !acc_done;
    rd_go = AVS_READ && !acc_done;
    idx   = AVS_ADDRESS[4:2];
    next_acc_done = (AVS_READ || AVS_WRITE) && !acc_done;
    next_rdata = rdata;
    if (rd_go) begin
      next_rdata = DEAD_WORD;
      if (AVS_ADDRESS == A_CTRL) next_rdata = ctrl;
      else if (AVS_ADDRESS == A_PORT_THR) next_rdata = port_thr;
      else if (AVS_ADDRESS == A_STATUS) next_rdata = {24'h000000, status};
      else if (AVS_ADDRESS == A_FILL) next_rdata = fill;
      else if (AVS_ADDRESS[11:5] == A_PRIO_PCT[11:5]) next_rdata = {25'h0000000, prio_pct[idx]};
      else if (AVS_ADDRESS[11:5] == A_MC_THR[11:5]) next_rdata = {16'h0000, mc_thr[idx]};
      else if (AVS_ADDRESS[11:5] == A_PROF_MAP[11:5]) next_rdata = {22'h000000, prof_map[idx]};
      else if (AVS_ADDRESS[11:4] == A_SLOT[11:4]) next_rdata = {1'b0, slot[idx[1:0]]};
      else if (AVS_ADDRESS == A_DROPS) next_rdata = drops;
      else if (AVS_ADDRESS == A_ACCEPTS) next_rdata = accepts;
    end
  end
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      acc_done <= 1'b0;
      waitreq  <= 1'b1;
      rdata    <= '0;
    end else begin
      acc_done <= next_acc_done;
      waitreq  <= !next_acc_done;
      rdata    <= next_rdata;
    end
  end
  assign AVS_WAITREQUEST = waitreq;
  assign AVS_READDATA    = rdata;

  ////////////////////////////////////////////////////////////////////////////
  // configuration writes with checks
  logic [9:0] pct_sum;
  logic       slot_busy;
  logic [8:0] wid;
  always_comb begin
    next_ctrl     = ctrl;
    next_port_thr = port_thr;
    next_status   = status;
    pct_sum = '0;
    for (int i = 0; i < NUM_PRIO; i++) begin
      pct_sum = pct_sum + ((wr_go && AVS_ADDRESS[11:5] == A_PRIO_PCT[11:5] && idx == 3'(i))
                ? 10'(AVS_WRITEDATA[6:0]) : 10'(prio_pct[i]));
    end
    wid = AVS_WRITEDATA[8:0];
    slot_busy = 1'b0;
    for (int s = 0; s < NUM_SLOT; s++) begin
      if (slot[s][9] && slot[s][8:0] != wid) slot_busy = slot_busy | 1'b0;
    end
    if (wr_go && AVS_ADDRESS == A_CTRL) next_ctrl = AVS_WRITEDATA;
    if (wr_go && AVS_ADDRESS == A_PORT_THR) next_port_thr = AVS_WRITEDATA;
    if (wr_go && AVS_ADDRESS == A_STATUS) next_status = status & ~AVS_WRITEDATA[7:0];
  end

  // a percentage write that would break the budget is refused and flagged
  logic pct_ok, map_ok;
  logic [1:0] slot_hit;
  logic       hit_any;
  always_comb begin
    // lowering a share is always let through, else the reset budget could never be cut
    pct_ok = (AVS_WRITEDATA[6:0] <= 7'(PCT_FULL))
             && ((pct_sum <= 10'(PCT_FULL)) || (AVS_WRITEDATA[6:0] <= prio_pct[idx]));
    hit_any  = 1'b0;
    slot_hit = '0;
    for (int s = 0; s < NUM_SLOT; s++) begin
      if (slot[s][9] && slot[s][8:0] == wid && !hit_any) begin
        hit_any  = 1'b1;
        slot_hit = 2'(s);
      end
    end
    // only profiles already held by a group slot can be mapped; ids above 384 refused
    map_ok = !AVS_WRITEDATA[9] || (hit_any && wid <= 9'(MAX_PROFILE));
  end

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      ctrl     <= '0;
      port_thr <= BUF_BYTES;
      status   <= '0;
      for (int i = 0; i < NUM_PRIO; i++) begin
        prio_pct[i] <= 7'(PCT_FULL);
        mc_thr[i]   <= 16'hFFFF;
        prof_map[i] <= '0;
      end
      for (int s = 0; s < NUM_SLOT; s++) slot[s] <= '0;
    end else begin
      ctrl     <= next_ctrl;
      port_thr <= next_port_thr;
      status   <= next_status;
      if (wr_go && AVS_ADDRESS[11:5] == A_PRIO_PCT[11:5]) begin
        if (pct_ok) prio_pct[idx] <= AVS_WRITEDATA[6:0];
        else status[ST_PCT_ERR] <= 1'b1;
      end
      if (wr_go && AVS_ADDRESS[11:5] == A_MC_THR[11:5]) mc_thr[idx] <= AVS_WRITEDATA[15:0];
      if (wr_go && AVS_ADDRESS[11:5] == A_PROF_MAP[11:5]) begin
        if (map_ok) prof_map[idx] <= {AVS_WRITEDATA[9], AVS_WRITEDATA[8:0]};
        else begin
          // failure records the rejected priority index in the status error field
          status[ST_MAP_ERR] <= 1'b1;
          status[ST_ERR_PRIO+:3] <= idx;
        end
      end
      if (wr_go && AVS_ADDRESS[11:4] == A_SLOT[11:4]) begin
        // trunk ports keep a private profile id space: flagged if trunk and id shared
        if (ctrl[CT_TRUNK] && AVS_WRITEDATA[31]) status[ST_TRUNK_ERR] <= 1'b1;
        else slot[idx[1:0]] <= {AVS_WRITEDATA[30:10], AVS_WRITEDATA[9] && (wid <= 9'(MAX_PROFILE)),
                                 wid};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // admission
  logic [2:0]    tc;
  logic [9:0]    pm;
  logic [30:0]   prof;
  logic [FW-1:0] prio_lim, min_b, max_b, pkt;
  logic [15:0]   prob_s;
  logic          drop, fifo_ready;
  qcd_reason_t   reason;
  always_comb begin
    tc       = IN_PRIO;
    pkt      = FW'(IN_LEN);
    pm       = prof_map[tc];
    prof     = slot[0];
    for (int s = 0; s < NUM_SLOT; s++) if (slot[s][8:0] == pm[8:0]) prof = slot[s];
    // no scaling: percentage of the port buffer as configured
    prio_lim = FW'((64'(port_thr) * 64'(prio_pct[tc])) / 64'(PCT_FULL));
    min_b    = FW'((64'(port_thr) * 64'(prof[30:24])) / 64'(PCT_FULL));
    max_b    = FW'((64'(port_thr) * 64'(prof[23:17])) / 64'(PCT_FULL));
    prob_s   = 16'((32'(prof[16:10]) * 32'h0000FFFF) / 32'(PCT_FULL));
    reason   = DR_NONE;
    if (fill + pkt > port_thr) reason = DR_PORT;
    else if (prio_fill[tc] + pkt > prio_lim) reason = DR_PRIO;
    else if (IN_MCAST && mc_cnt[tc] >= mc_thr[tc]) reason = DR_MCAST;
    else if (pm[9] && fill > max_b) reason = DR_MAXFILL;
    else if (pm[9] && fill >= min_b && lfsr < prob_s) reason = DR_RANDOM;
    drop = (reason != DR_NONE);
    next_lfsr = IN_VALID ? ((lfsr >> 1) ^ (lfsr[0] ? LFSR_TAPS : 16'h0000)) : lfsr;
  end

  logic acc, take;
  always_comb begin
    take = IN_VALID && fifo_ready;
    acc  = take && !drop;
    next_drops   = (take && drop) ? drops + 32'h00000001 : drops;
    next_accepts = acc ? accepts + 32'h00000001 : accepts;
    next_fill    = fill + (acc ? pkt : '0) - (OUT_FREE ? FW'(OUT_FREE_LEN) : '0);
  end

  logic out_mc;
  logic [2:0] out_tc;
  assign out_tc = OUT_DESC[2:0];
  assign out_mc = OUT_DESC[3];

  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      fill        <= '0;
      lfsr        <= LFSR_SEED;
      drops       <= '0;
      accepts     <= '0;
      DROP_PULSE  <= 1'b0;
      DROP_REASON <= DR_NONE;
      for (int i = 0; i < NUM_PRIO; i++) begin
        prio_fill[i] <= '0;
        mc_cnt[i]    <= '0;
      end
    end else begin
      fill        <= next_fill;
      lfsr        <= next_lfsr;
      drops       <= next_drops;
      accepts     <= next_accepts;
      DROP_PULSE  <= take && drop;
      DROP_REASON <= take ? reason : DR_NONE;
      for (int i = 0; i < NUM_PRIO; i++) begin
        prio_fill[i] <= prio_fill[i] + ((acc && tc == 3'(i)) ? pkt : '0)
                        - ((OUT_FREE && out_tc == 3'(i)) ? FW'(OUT_FREE_LEN) : '0);
        mc_cnt[i] <= 16'(mc_cnt[i] + ((acc && IN_MCAST && tc == 3'(i)) ? 16'h0001 : 16'h0000)
                     - ((OUT_FREE && out_mc && out_tc == 3'(i)) ? 16'h0001 : 16'h0000));
      end
    end
  end

  // in order delivery toward egress
  qcd_fifo #(.WIDTH(LEN_W+4), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (CLOCK),
    .rst       (SYS_RST),
    .in_valid  (acc),
    .in_ready  (fifo_ready),
    .in_data   ({IN_LEN, IN_MCAST, IN_PRIO}),
    .out_valid (OUT_VALID),
    .out_ready (OUT_READY),
    .out_data  (OUT_DESC)
  );
  assign IN_READY = fifo_ready;
endmodule // qcd_top

`default_nettype wire

// >>> inc/qcd_pkg.sv
// Purpose: constants for the queue congestion drop controller
// Assumes: single core clock, synchronous reset
// Notes: register map on Avalon-MM, byte addresses
package qcd_pkg;
  localparam int unsigned CLK_MHZ     = 100;
  localparam int unsigned NUM_PRIO    = 8;
  localparam int unsigned NUM_TC      = 8;
  localparam int unsigned MAX_PROFILE = 384;
  localparam int unsigned NUM_SLOT    = 4;
  localparam int unsigned PCT_FULL    = 100;
  localparam int unsigned FIFO_DEPTH  = 16;
  // byte addresses
  localparam logic [11:0] A_CTRL      = 12'h000;
  localparam logic [11:0] A_PORT_THR  = 12'h004;
  localparam logic [11:0] A_STATUS    = 12'h008;
  localparam logic [11:0] A_FILL      = 12'h00C;
  localparam logic [11:0] A_PRIO_PCT  = 12'h040;
  localparam logic [11:0] A_MC_THR    = 12'h060;
  localparam logic [11:0] A_PROF_MAP  = 12'h080;
  localparam logic [11:0] A_SLOT      = 12'h0A0;
  localparam logic [11:0] A_DROPS     = 12'h0C0;
  localparam logic [11:0] A_ACCEPTS   = 12'h0C4;
  localparam logic [31:0] DEAD_WORD   = 32'hDEADBEEF;
  localparam logic [15:0] LFSR_SEED   = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS   = 16'hB400;
  // status bits
  localparam int unsigned ST_PCT_ERR  = 0;
  localparam int unsigned ST_MAP_ERR  = 1;
  localparam int unsigned ST_TRUNK_ERR = 2;
  localparam int unsigned ST_ERR_PRIO = 4;
  // ctrl bits
  localparam int unsigned CT_TRUNK    = 0;
  localparam int unsigned CT_MEMBER   = 8;
  // drop reasons
  typedef enum logic [2:0] {
    DR_NONE    = 3'b000,
    DR_PORT    = 3'b001,
    DR_PRIO    = 3'b010,
    DR_MCAST   = 3'b011,
    DR_RANDOM  = 3'b100,
    DR_MAXFILL = 3'b101
  } qcd_reason_t;
endpackage

// >>> dv/qcd_top_checker.sv
// Purpose: port assertions for qcd_top
// Assumes: one clock, sync reset
// Notes: bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module qcd_top_checker import qcd_pkg::*; #(
  parameter int unsigned LEN_W = 14
) (
  input wire logic             CLOCK,
  input wire logic             SYS_RST,
  input wire logic [11:0]      AVS_ADDRESS,
  input wire logic             AVS_READ,
  input wire logic             AVS_WRITE,
  input wire logic [31:0]      AVS_READDATA,
  input wire logic             AVS_WAITREQUEST,
  input wire logic             IN_VALID,
  input wire logic             IN_READY,
  input wire logic             DROP_PULSE,
  input wire logic [2:0]       DROP_REASON,
  input wire logic             OUT_VALID,
  input wire logic             OUT_READY,
  input wire logic [LEN_W+3:0] OUT_DESC
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////////////
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_ans;
    !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endsequence
  property p_one_wait;
    s_req |=> s_ans;
  endproperty
  property p_dead;
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == 12'hFFC |-> AVS_READDATA == DEAD_WORD;
  endproperty
  property p_drop_cause;
    DROP_PULSE |-> $past(IN_VALID && IN_READY);
  endproperty
  property p_reason;
    DROP_PULSE |-> DROP_REASON inside {DR_PORT, DR_PRIO, DR_MCAST, DR_RANDOM, DR_MAXFILL};
  endproperty
  property p_take;
    IN_VALID && IN_READY |=> DROP_PULSE || OUT_VALID;
  endproperty
  property p_room;
    !OUT_VALID |-> IN_READY;
  endproperty
  property p_hold;
    OUT_VALID && !OUT_READY |=> OUT_VALID && $stable(OUT_DESC);
  endproperty
  property p_rst;
    $past(SYS_RST) |-> AVS_WAITREQUEST && !OUT_VALID && !DROP_PULSE;
  endproperty
  // answer after exactly one wait, held one cycle only
  a_one_wait: assert property (p_one_wait)
    else $error("bus answer timing wrong");
  a_dead: assert property (p_dead)
    else $error("unmapped read data wrong");
  a_drop_cause: assert property (p_drop_cause)
    else $error("drop without a take");
  a_reason: assert property (p_reason)
    else $error("drop reason invalid");
  a_take: assert property (p_take)
    else $error("taken frame vanished");
  a_room: assert property (p_room)
    else $error("refused while queue empty");
  a_hold: assert property (p_hold)
    else $error("queue head changed while stalled");
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
endmodule // qcd_top_checker

bind qcd_top qcd_top_checker #(.LEN_W(LEN_W)) u_chk (
  .CLOCK(CLOCK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .IN_VALID(IN_VALID), .IN_READY(IN_READY), .DROP_PULSE(DROP_PULSE),
  .DROP_REASON(DROP_REASON), .OUT_VALID(OUT_VALID), .OUT_READY(OUT_READY),
  .OUT_DESC(OUT_DESC));
`default_nettype wire

// >>> dv/qcd_egress_model.sv
// Purpose: egress scheduler model, pops and frees frames
// Assumes: free pulse goes with the pop
// Notes: stall stops all pops; popped lengths are logged in order
`timescale 1ns/1ps
`default_nettype none
module qcd_egress_model #(
  parameter int unsigned LEN_W = 14
) (
  input  wire logic             clk,
  input  wire logic             stall,
  input  wire logic             out_valid,
  output logic                  out_ready,
  input  wire logic [LEN_W+3:0] out_desc,
  output logic                  out_free,
  output logic [LEN_W-1:0]      out_free_len
);
  logic [LEN_W-1:0] got[$];
  assign out_ready = !stall;
  assign out_free = out_valid && out_ready;
  // length is meaningless outside a free, so it is scrambled there
  assign out_free_len = out_free ? out_desc[LEN_W+3:4] : ~out_desc[LEN_W+3:4];
  always @(posedge clk) if (out_free) got.push_back(out_free_len);
endmodule // qcd_egress_model
`default_nettype wire

// >>> dv/queue_congestion_drop_control_bench.sv
// Purpose: self-checking bench for qcd_top
// Assumes: 100 MHz clock, reset held two cycles
// Notes: percentage sums start above 100, so shares can only be lowered at first
`timescale 1ns/1ps
`default_nettype none
module queue_congestion_drop_control_bench import qcd_pkg::*;;
  localparam int unsigned LW = 14;
  logic CLOCK, SYS_RST, AVS_READ, AVS_WRITE, AVS_WAITREQUEST, IN_VALID, IN_READY, IN_MCAST;
  logic DROP_PULSE, OUT_VALID, OUT_READY, OUT_FREE, stall;
  logic [11:0] AVS_ADDRESS;
  logic [31:0] AVS_WRITEDATA, AVS_READDATA, q;
  logic [LW-1:0] IN_LEN, OUT_FREE_LEN;
  logic [2:0] IN_PRIO, DROP_REASON;
  logic [LW+3:0] OUT_DESC;
  int failures, cmp_count, cyc;
  qcd_top #(.LEN_W(LW)) DUT (
    .CLOCK(CLOCK), .SYS_RST(SYS_RST), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_BYTEENABLE(4'hF),
    .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .IN_VALID(IN_VALID),
    .IN_READY(IN_READY), .IN_LEN(IN_LEN), .IN_PRIO(IN_PRIO), .IN_MCAST(IN_MCAST),
    .DROP_PULSE(DROP_PULSE), .DROP_REASON(DROP_REASON), .OUT_VALID(OUT_VALID),
    .OUT_READY(OUT_READY), .OUT_DESC(OUT_DESC), .OUT_FREE(OUT_FREE),
    .OUT_FREE_LEN(OUT_FREE_LEN));
  qcd_egress_model #(.LEN_W(LW)) eg (
    .clk(CLOCK), .stall(stall), .out_valid(OUT_VALID), .out_ready(OUT_READY),
    .out_desc(OUT_DESC), .out_free(OUT_FREE), .out_free_len(OUT_FREE_LEN));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge CLOCK) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      report_and_stop;
    end
  end
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] s);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", w, e, s);
    end
  endtask
  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= wr;
    AVS_READ <= !wr;
    do @(posedge CLOCK); while (AVS_WAITREQUEST !== 1'b0);
    q = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
  endtask
  task automatic rdc(input string w, input logic [11:0] a, input logic [31:0] e, m);
    bus(1'b0, a, 32'h0);
    chk(w, e, q & m);
  endtask
  // ck low: outcome left unchecked; used to build up the multicast count or to repeat a drop before the checked send
  task automatic send(input logic [LW-1:0] l, input logic mc, ck, dr, input logic [2:0] why);
    @(posedge CLOCK);
    IN_LEN <= l;
    IN_MCAST <= mc;
    IN_VALID <= 1'b1;
    do @(posedge CLOCK); while (IN_READY !== 1'b1);
    IN_VALID <= 1'b0;
    @(negedge CLOCK);
    if (ck) chk("drop", {31'h0, dr}, {31'h0, DROP_PULSE});
    if (ck && dr) chk("reason", {29'h0, why}, {29'h0, DROP_REASON});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    rdc("port_thr", A_PORT_THR, 32'h00010000, 32'hFFFFFFFF);
    rdc("prio_pct", A_PRIO_PCT + 12'h01C, 32'h64, 32'hFFFFFFFF);
    rdc("mc_thr", A_MC_THR + 12'h01C, 32'hFFFF, 32'hFFFFFFFF);
    rdc("unmapped", 12'hFFC, DEAD_WORD, 32'hFFFFFFFF);
    bus(1'b1, A_PRIO_PCT, 32'h65);
    rdc("pct_err", A_STATUS, 32'h1, 32'h7);
    rdc("pct_kept", A_PRIO_PCT, 32'h64, 32'hFFFFFFFF);
    bus(1'b1, A_STATUS, 32'h7);
    rdc("cleared", A_STATUS, 32'h0, 32'h7);
    bus(1'b1, A_PROF_MAP, 32'h20A);
    rdc("map_err", A_STATUS, 32'h2, 32'h7);
  endtask
  task automatic t_order;
    int n;
    stall <= 1'b1;
    for (int i = 0; i < 16; i++) send(LW'(i + 1), 1'b0, 1'b1, 1'b0, DR_NONE);
    chk("full", 32'h0, {31'h0, IN_READY});
    stall <= 1'b0;
    n = 0;
    while (eg.got.size() < 16 && n < 100) begin
      @(posedge CLOCK);
      n++;
    end
    for (int i = 0; i < 16; i++) chk("order", i + 1, 32'(eg.got[i]));
  endtask
  task automatic t_drop;
    stall <= 1'b1;
    bus(1'b1, A_PORT_THR, 32'd50);
    send(14'd60, 1'b0, 1'b0, 1'b0, DR_NONE);
    send(14'd60, 1'b0, 1'b1, 1'b1, DR_PORT);
    bus(1'b1, A_PORT_THR, 32'h00010000);
    for (int i = 0; i < 8; i++) bus(1'b1, A_MC_THR + 12'(4 * i), 32'h1);
    send(14'd4, 1'b1, 1'b0, 1'b0, DR_NONE);
    send(14'd4, 1'b1, 1'b0, 1'b0, DR_NONE);
    send(14'd4, 1'b1, 1'b1, 1'b1, DR_MCAST);
    send(14'd4, 1'b0, 1'b1, 1'b0, DR_NONE);
    bus(1'b1, A_PRIO_PCT, 32'h0);
    rdc("pct_low", A_PRIO_PCT, 32'h0, 32'hFFFFFFFF);
    send(14'd4, 1'b0, 1'b1, 1'b1, DR_PRIO);
    stall <= 1'b0;
  endtask
  initial begin
    SYS_RST = 1'b1;
    AVS_READ = 1'b0;
    AVS_WRITE = 1'b0;
    AVS_ADDRESS = 12'h000;
    AVS_WRITEDATA = 32'h0;
    IN_VALID = 1'b0;
    IN_LEN = '0;
    IN_PRIO = 3'h0;
    IN_MCAST = 1'b0;
    stall = 1'b0;
    repeat (2) @(posedge CLOCK);
    SYS_RST <= 1'b0;
    t_regs;
    t_order;
    t_drop;
    repeat (20) @(posedge CLOCK);
    report_and_stop;
  end
endmodule // queue_congestion_drop_control_bench
`default_nettype wire
